// File: rtl/delay_timer.sv
`timescale 1ns/1ps
module delay_timer
	import trig_seq_pkg::*;
#(
	parameter int TICKS = TICK_CYCLES
)
(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Control
	input  wire logic        start,
	input  wire logic [15:0] seconds,
	input  wire logic        abort,
	// Status
	output logic             busy,
	output logic             done
);

	logic [31:0] tick_q;
	logic [15:0] sec_q;
	logic        busy_q;
	logic        done_q;

	assign busy = busy_q;
	assign done = done_q;

	// Whole-second counter built from a fixed clock tick
	always_ff @(posedge aclk)
	begin
		if (!aresetn || abort)
		begin
			busy_q <= 1'b0;
			done_q <= 1'b0;
			tick_q <= 32'h0000_0000;
			sec_q  <= 16'h0000;
		end
		else if (start && !busy_q)
		begin
			busy_q <= (seconds != 16'h0000);
			done_q <= (seconds == 16'h0000);
			tick_q <= 32'h0000_0000;
			sec_q  <= seconds;
		end
		else if (busy_q)
		begin
			done_q <= 1'b0;
			if (tick_q == 32'(TICKS - 1))
			begin
				tick_q <= 32'h0000_0000;
				sec_q  <= sec_q - 16'h0001;
				if (sec_q == 16'h0001)
				begin
					busy_q <= 1'b0;
					done_q <= 1'b1;
				end
			end
			else
				tick_q <= tick_q + 32'h0000_0001;
		end
		else
			done_q <= 1'b0;
	end

endmodule : delay_timer

// File: rtl/err_queue.sv
`timescale 1ns/1ps
module err_queue
	import trig_seq_pkg::*;
(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Push side
	input  wire logic        push,
	input  wire logic [15:0] push_code,
	// Pop side
	input  wire logic        pop,
	input  wire logic        clear,
	output logic      [15:0] head_code,
	output logic             not_empty,
	output logic      [4:0]  count
);

	logic [15:0] mem [ERRQ_DEPTH];
	logic [4:0]  rd_q;
	logic [4:0]  wr_q;
	logic [4:0]  cnt_q;
	logic        lock_q;
	logic        do_pop;
	logic        full;

	// Wrapping pointer advance
	function automatic logic [4:0] next_ptr(input logic [4:0] p);
		next_ptr = (p == 5'(ERRQ_DEPTH - 1)) ? 5'h00 : p + 5'h01;
	endfunction : next_ptr

	function automatic logic [4:0] prev_ptr(input logic [4:0] p);
		prev_ptr = (p == 5'h00) ? 5'(ERRQ_DEPTH - 1) : p - 5'h01;
	endfunction : prev_ptr

	assign full      = (cnt_q == 5'(ERRQ_DEPTH));
	assign do_pop    = pop && (cnt_q != 5'h00);
	assign not_empty = (cnt_q != 5'h00);
	assign count     = cnt_q;
	assign head_code = not_empty ? mem[rd_q] : ERR_NONE;

	// Storage; when full the newest slot becomes the overflow code
	always_ff @(posedge aclk)
	begin
		if (push && !full && !lock_q)
			mem[wr_q] <= push_code;
		else if (push && full && !lock_q && !do_pop)
			mem[prev_ptr(wr_q)] <= ERR_OVERFLOW;
	end

	// Pointers and count
	always_ff @(posedge aclk)
	begin
		if (!aresetn || clear)
		begin
			rd_q  <= 5'h00;
			wr_q  <= 5'h00;
			cnt_q <= 5'h00;
		end
		else
		begin
			if (do_pop)
				rd_q <= next_ptr(rd_q);
			if (push && !full && !lock_q)
				wr_q <= next_ptr(wr_q);
			if ((push && !full && !lock_q) && !do_pop)
				cnt_q <= cnt_q + 5'h01;
			else if (!(push && !full && !lock_q) && do_pop)
				cnt_q <= cnt_q - 5'h01;
		end
	end

	// Overflow lock holds off storing until the queue is cleared or read empty
	always_ff @(posedge aclk)
	begin
		if (!aresetn || clear)
			lock_q <= 1'b0;
		else if (push && full && !do_pop)
			lock_q <= 1'b1;
		else if (cnt_q == 5'h00)
			lock_q <= 1'b0;
	end

endmodule : err_queue

// File: rtl/trig_seq.sv
`timescale 1ns/1ps
// Functional notes
// - Errors read back oldest first
// - Twenty entries; overflow writes -350, then locks
// - Error read gives code; empty reads none
// - Interface select picks active port
// - Bus address writable and readable
// - Version reads four year digits, revision
// - Reset selects bus trigger source
// - Bus trigger copies staged after delay
// - Unarmed bus trigger dropped, queues -211
// - Immediate source: arm copies at once
// - Immediate source ignores bus trigger
// - Staged values track active until programmed
// - Programmed staged values persist
// - Staged write spares active; min/max keys
// - Min/max queries return limits
// - Delay 0 to 36000 s, reset zero
// - Immediate source ignores delay
// - Source query reports bus or immediate
// - Pending delay refuses other commands
// - Local key during pending delay applies staged, goes local
// - Save captures staged, delay, source
module trig_seq
	import trig_seq_pkg::*;
#(
	parameter int TICKS = TICK_CYCLES
)
(
	// Clock and reset
	input  wire logic            aclk,
	input  wire logic            aresetn,
	// AXI4-Lite write address
	input  wire logic [7:0]      s_axi_awaddr,
	input  wire logic            s_axi_awvalid,
	output logic                 s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0]     s_axi_wdata,
	input  wire logic [3:0]      s_axi_wstrb,
	input  wire logic            s_axi_wvalid,
	output logic                 s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]           s_axi_bresp,
	output logic                 s_axi_bvalid,
	input  wire logic            s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [7:0]      s_axi_araddr,
	input  wire logic            s_axi_arvalid,
	output logic                 s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]          s_axi_rdata,
	output logic [1:0]           s_axi_rresp,
	output logic                 s_axi_rvalid,
	input  wire logic            s_axi_rready,
	// Front panel
	input  wire logic            local_key,
	output logic                 local_mode,
	// Error injection from other command logic
	input  wire logic            err_push,
	input  wire logic [15:0]     err_code,
	// Setpoints, port choice and saved state
	output setpoint_type         active_setpoint,
	output logic                 iface_serial,
	output logic [4:0]           bus_address,
	output saved_state_type      saved_state,
	output logic                 save_strobe
);

	// ****************************************************
	// Declarations
	// ****************************************************
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	localparam logic [1:0] RESP_DECERR = 2'b11;

	logic          aw_held_q;
	logic [7:0]    awaddr_q;
	logic          w_held_q;
	logic [31:0]   wdata_q;
	logic [3:0]    wstrb_q;
	logic          bvalid_q;
	logic [1:0]    bresp_q;
	logic          rvalid_q;
	logic [31:0]   rdata_q;
	logic [1:0]    rresp_q;

	logic          wr_fire;
	logic          wr_ok;
	logic          wr_mapped;
	logic          rd_fire;
	logic          rd_mapped;

	seq_state_type state_q;
	logic          src_imm_q;
	logic          iface_q;
	logic [4:0]    addr_q;
	logic [15:0]   delay_q;
	logic [1:0]    qsel_q;
	setpoint_type  act_q;
	setpoint_type  stg_q;
	logic          stg_v_prog_q;
	logic          stg_i_prog_q;
	logic          local_q;
	saved_state_type saved_q;
	logic          save_q;

	setpoint_type  eff_stg;
	logic          cmd_arm;
	logic          cmd_trig;
	logic          cmd_rst;
	logic          cmd_save;
	logic          cmd_clrq;
	logic          cmd_remote;
	logic          bus_trig_ok;
	logic          copy_now;
	logic          timer_start;
	logic          timer_busy;
	logic          timer_done;
	logic          local_abort;
	logic          err_pop;
	logic          q_push;
	logic [15:0]   q_code;
	logic [15:0]   head_code;
	logic          q_not_empty;
	logic [4:0]    q_count;

	// Value write with min/max keyword, clamped to the ceiling
	function automatic logic [15:0] keyed(input logic [31:0] d,
		input logic [15:0] ceil);
		unique case (d[KEY_LSB +: 2])
			KEY_MIN: keyed = VAL_MIN;
			KEY_MAX: keyed = ceil;
			default: keyed = (d[15:0] > ceil) ? ceil : d[15:0];
		endcase
	endfunction : keyed

	// Query answer: stored value or the fixed limits
	function automatic logic [15:0] query(input logic [1:0] sel,
		input logic [15:0] val, input logic [15:0] ceil);
		unique case (sel)
			KEY_MIN: query = VAL_MIN;
			KEY_MAX: query = ceil;
			default: query = val;
		endcase
	endfunction : query

	// ****************************************************
	// AXI4-Lite channel handshakes
	// ****************************************************
	assign s_axi_awready = !aw_held_q;
	assign s_axi_wready  = !w_held_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

	assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
	assign rd_fire = s_axi_arvalid && !rvalid_q;

	// Address and data may arrive in either order
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_q <= 1'b0;
			w_held_q  <= 1'b0;
			awaddr_q  <= 8'h00;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && !aw_held_q)
			begin
				aw_held_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			else if (wr_fire)
				aw_held_q <= 1'b0;
			if (s_axi_wvalid && !w_held_q)
			begin
				w_held_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
			else if (wr_fire)
				w_held_q <= 1'b0;
		end
	end

	// Write decode; partial words are not supported
	always_comb
	begin
		unique case (awaddr_q)
			CTRL_OFS, CMD_OFS, STG_V_OFS, STG_I_OFS, DELAY_OFS,
			ACT_V_OFS, ACT_I_OFS, QSEL_OFS: wr_mapped = 1'b1;
			default:                        wr_mapped = 1'b0;
		endcase
	end
	// Nothing is applied while a delayed copy is pending
	assign wr_ok = wr_fire && wr_mapped && (wstrb_q == 4'hF)
		&& (state_q != ST_PENDING);

	// Write response
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end
		else if (wr_fire)
		begin
			bvalid_q <= 1'b1;
			if (!wr_mapped)
				bresp_q <= RESP_DECERR;
			else if (!wr_ok)
				bresp_q <= RESP_SLVERR;
			else
				bresp_q <= RESP_OKAY;
		end
		else if (s_axi_bready)
			bvalid_q <= 1'b0;
	end

	// ****************************************************
	// Command strobes
	// ****************************************************
	assign cmd_arm    = wr_ok && awaddr_q == CMD_OFS && wdata_q[CMD_ARM_BIT];
	assign cmd_trig   = wr_ok && awaddr_q == CMD_OFS && wdata_q[CMD_TRIG_BIT];
	assign cmd_rst    = wr_ok && awaddr_q == CMD_OFS && wdata_q[CMD_RST_BIT];
	assign cmd_save   = wr_ok && awaddr_q == CMD_OFS && wdata_q[CMD_SAVE_BIT];
	assign cmd_clrq   = wr_ok && awaddr_q == CMD_OFS && wdata_q[CMD_CLRQ_BIT];
	assign cmd_remote = wr_ok && awaddr_q == CMD_OFS
		&& wdata_q[CMD_REMOTE_BIT];

	// Bus trigger only counts with bus source and an armed sequencer
	assign bus_trig_ok = cmd_trig && !src_imm_q && state_q == ST_ARMED;
	assign timer_start = bus_trig_ok && !cmd_rst;
	assign local_abort = local_key && state_q == ST_PENDING;

	// Any of these moves staged values into the active setpoints
	assign copy_now = !cmd_rst && ((cmd_arm && src_imm_q)
		|| timer_done
		|| local_abort);

	// Staged values follow the active ones until programmed
	assign eff_stg.volt = stg_v_prog_q ? stg_q.volt : act_q.volt;
	assign eff_stg.curr = stg_i_prog_q ? stg_q.curr : act_q.curr;

	// ****************************************************
	// Sequencer state
	// ****************************************************
	always_ff @(posedge aclk)
	begin
		if (!aresetn || cmd_rst)
			state_q <= ST_IDLE;
		else
			unique case (state_q)
				ST_IDLE:
					if (cmd_arm && !src_imm_q)
						state_q <= ST_ARMED;
				ST_ARMED:
					if (bus_trig_ok)
						state_q <= ST_PENDING;
				ST_PENDING:
					if (timer_done || local_abort)
						state_q <= ST_IDLE;
				default:
					state_q <= ST_IDLE;
			endcase
	end

	delay_timer #(
		.TICKS   (TICKS)
	) u_delay (
		.aclk    (aclk),
		.aresetn (aresetn),
		.start   (timer_start),
		.seconds (delay_q),
		.abort   (local_abort),
		.busy    (timer_busy),
		.done    (timer_done)
	);

	// ****************************************************
	// Configuration registers
	// ****************************************************
	always_ff @(posedge aclk)
	begin
		if (!aresetn || cmd_rst)
		begin
			src_imm_q <= 1'b0;
			delay_q   <= DELAY_RST;
			qsel_q    <= KEY_VALUE;
		end
		else if (wr_ok)
		begin
			if (awaddr_q == CTRL_OFS)
				src_imm_q <= wdata_q[CTRL_SRC_BIT];
			if (awaddr_q == DELAY_OFS)
				delay_q <= keyed(wdata_q, DELAY_MAX_SEC);
			if (awaddr_q == QSEL_OFS)
				qsel_q <= wdata_q[1:0];
		end
	end

	// Port choice and bus address survive a reset command
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			iface_q <= 1'b0;
			addr_q  <= ADDR_RST;
		end
		else if (wr_ok && awaddr_q == CTRL_OFS)
		begin
			iface_q <= wdata_q[CTRL_IFACE_BIT];
			addr_q  <= wdata_q[CTRL_ADDR_LSB +: 5];
		end
	end

	// Staged values; only an explicit write or reset changes them
	always_ff @(posedge aclk)
	begin
		if (!aresetn || cmd_rst)
		begin
			stg_q        <= '0;
			stg_v_prog_q <= 1'b0;
			stg_i_prog_q <= 1'b0;
		end
		else if (wr_ok && awaddr_q == STG_V_OFS)
		begin
			stg_q.volt   <= keyed(wdata_q, VOLT_MAX);
			stg_v_prog_q <= 1'b1;
		end
		else if (wr_ok && awaddr_q == STG_I_OFS)
		begin
			stg_q.curr   <= keyed(wdata_q, CURR_MAX);
			stg_i_prog_q <= 1'b1;
		end
	end

	// Active setpoints: direct writes or a trigger copy
	always_ff @(posedge aclk)
	begin
		if (!aresetn || cmd_rst)
			act_q <= '0;
		else if (copy_now)
			act_q <= eff_stg;
		else if (wr_ok && awaddr_q == ACT_V_OFS)
			act_q.volt <= keyed(wdata_q, VOLT_MAX);
		else if (wr_ok && awaddr_q == ACT_I_OFS)
			act_q.curr <= keyed(wdata_q, CURR_MAX);
	end

	// Local mode entered from the panel key during a pending delay
	always_ff @(posedge aclk)
	begin
		if (!aresetn || cmd_remote)
			local_q <= 1'b0;
		else if (local_abort)
			local_q <= 1'b1;
	end

	// Snapshot of the trigger settings for state storage
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			saved_q <= '0;
			save_q  <= 1'b0;
		end
		else
		begin
			save_q <= cmd_save;
			if (cmd_save)
			begin
				saved_q.staged  <= eff_stg;
				saved_q.delay   <= delay_q;
				saved_q.src_imm <= src_imm_q;
			end
		end
	end

	// ****************************************************
	// Error queue
	// ****************************************************
	// Trigger error wins over a simultaneous external push
	assign q_push = (cmd_trig && !src_imm_q && state_q != ST_ARMED)
		|| err_push;
	assign q_code = (cmd_trig && !src_imm_q && state_q != ST_ARMED)
		? ERR_TRIG_IGN : err_code;
	assign err_pop = rd_fire && s_axi_araddr == ERR_OFS
		&& state_q != ST_PENDING;

	err_queue u_errq (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.push      (q_push),
		.push_code (q_code),
		.pop       (err_pop),
		.clear     (cmd_clrq),
		.head_code (head_code),
		.not_empty (q_not_empty),
		.count     (q_count)
	);

	// ****************************************************
	// Read path
	// ****************************************************
	always_comb
	begin
		unique case (s_axi_araddr)
			CTRL_OFS, STG_V_OFS, STG_I_OFS, DELAY_OFS, ACT_V_OFS,
			ACT_I_OFS, QSEL_OFS, ERR_OFS, STATUS_OFS,
			VERSION_OFS: rd_mapped = 1'b1;
			default:     rd_mapped = 1'b0;
		endcase
	end

	// Reads are refused too while a delayed copy is pending
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= RESP_OKAY;
		end
		else if (rd_fire)
		begin
			rvalid_q <= 1'b1;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= RESP_OKAY;
			if (!rd_mapped)
				rresp_q <= RESP_DECERR;
			else if (state_q == ST_PENDING)
				rresp_q <= RESP_SLVERR;
			else
				unique case (s_axi_araddr)
					CTRL_OFS:
					begin
						rdata_q[CTRL_SRC_BIT]       <= src_imm_q;
						rdata_q[CTRL_IFACE_BIT]     <= iface_q;
						rdata_q[CTRL_ADDR_LSB +: 5] <= addr_q;
					end
					STG_V_OFS:
						rdata_q[15:0] <= query(qsel_q, eff_stg.volt,
							VOLT_MAX);
					STG_I_OFS:
						rdata_q[15:0] <= query(qsel_q, eff_stg.curr,
							CURR_MAX);
					DELAY_OFS:
						rdata_q[15:0] <= query(qsel_q, delay_q,
							DELAY_MAX_SEC);
					ACT_V_OFS: rdata_q[15:0] <= act_q.volt;
					ACT_I_OFS: rdata_q[15:0] <= act_q.curr;
					QSEL_OFS:  rdata_q[1:0]  <= qsel_q;
					ERR_OFS:
					begin
						rdata_q[15:0]         <= head_code;
						rdata_q[ERR_VALID_BIT] <= q_not_empty;
					end
					STATUS_OFS:
						rdata_q[9:0] <= {local_q, q_count, q_not_empty,
							timer_busy, state_q};
					VERSION_OFS:
						rdata_q[19:0] <= VERSION_BCD;
					default:
						rdata_q <= 32'h0000_0000;
				endcase
		end
		else if (s_axi_rready)
			rvalid_q <= 1'b0;
	end

	// ****************************************************
	// Outputs
	// ****************************************************
	assign active_setpoint = act_q;
	assign iface_serial    = iface_q;
	assign bus_address     = addr_q;
	assign local_mode      = local_q;
	assign saved_state     = saved_q;
	assign save_strobe     = save_q;

endmodule : trig_seq

// File: rtl/trig_seq_pkg.sv
package trig_seq_pkg;

	// ****************************************************
	// Register offsets (byte addresses)
	// ****************************************************
	localparam logic [7:0] CTRL_OFS    = 8'h00;
	localparam logic [7:0] CMD_OFS     = 8'h04;
	localparam logic [7:0] STG_V_OFS   = 8'h08;
	localparam logic [7:0] STG_I_OFS   = 8'h0C;
	localparam logic [7:0] DELAY_OFS   = 8'h10;
	localparam logic [7:0] ACT_V_OFS   = 8'h14;
	localparam logic [7:0] ACT_I_OFS   = 8'h18;
	localparam logic [7:0] QSEL_OFS    = 8'h1C;
	localparam logic [7:0] ERR_OFS     = 8'h20;
	localparam logic [7:0] STATUS_OFS  = 8'h24;
	localparam logic [7:0] VERSION_OFS = 8'h28;

	// ****************************************************
	// Field positions
	// ****************************************************
	localparam int CTRL_SRC_BIT   = 0;
	localparam int CTRL_IFACE_BIT = 1;
	localparam int CTRL_ADDR_LSB  = 4;
	localparam int CMD_ARM_BIT    = 0;
	localparam int CMD_TRIG_BIT   = 1;
	localparam int CMD_RST_BIT    = 2;
	localparam int CMD_SAVE_BIT   = 3;
	localparam int CMD_CLRQ_BIT   = 4;
	localparam int CMD_REMOTE_BIT = 5;
	localparam int KEY_LSB        = 16;
	localparam int ERR_VALID_BIT  = 16;

	// ****************************************************
	// Limits, codes and reset values
	// ****************************************************
	localparam logic [15:0] VAL_MIN       = 16'h0000;
	localparam logic [15:0] VOLT_MAX      = 16'h7530;
	localparam logic [15:0] CURR_MAX      = 16'h2710;
	localparam logic [15:0] DELAY_MAX_SEC = 16'h8CA0; // 36,000 s
	localparam logic [15:0] DELAY_RST     = 16'h0000;
	localparam logic [4:0]  ADDR_RST      = 5'h05;
	localparam logic [15:0] ERR_TRIG_IGN  = 16'hFF2D; // -211
	localparam logic [15:0] ERR_OVERFLOW  = 16'hFEA2; // -350
	localparam logic [15:0] ERR_NONE      = 16'h0000;
	localparam int          ERRQ_DEPTH    = 20;
	// Arbitrary neutral version, year and revision digits in BCD
	localparam logic [19:0] VERSION_BCD   = 20'h2000_0;

	// ****************************************************
	// Timing
	// ****************************************************
	localparam int CLK_HZ      = 20_000_000;
	localparam int SEC_UNIT    = 1;
	localparam int TICK_CYCLES = CLK_HZ * SEC_UNIT;

	// ****************************************************
	// Types
	// ****************************************************
	typedef enum logic [1:0]
	{
		KEY_VALUE = 2'b00,
		KEY_MIN   = 2'b01,
		KEY_MAX   = 2'b10
	} key_type;

	typedef enum logic [1:0]
	{
		ST_IDLE    = 2'b00,
		ST_ARMED   = 2'b01,
		ST_PENDING = 2'b10
	} seq_state_type;

	typedef struct packed
	{
		logic [15:0] volt;
		logic [15:0] curr;
	} setpoint_type;

	typedef struct packed
	{
		setpoint_type staged;
		logic [15:0]  delay;
		logic         src_imm;
	} saved_state_type;

endpackage : trig_seq_pkg

// File: tb/host_ctl.sv
`timescale 1ns/1ps
// ****
// Remote host: one write and one read at a time
// ****
module host_ctl
(
	// Clock
	input  wire logic        aclk,
	// Write side
	output logic [7:0]       s_axi_awaddr,
	output logic             s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output logic [31:0]      s_axi_wdata,
	output logic [3:0]       s_axi_wstrb,
	output logic             s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	output logic             s_axi_bready,
	// Read side
	output logic [7:0]       s_axi_araddr,
	output logic             s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	output logic             s_axi_rready
);
	int lag = 0;
	// Answers always welcome; released lines show inverted data
	initial
	begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'b000;
		{s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
	end
	task automatic give_up;
		tb_top.bad_count++;
		tb_top.end_sim();
	endtask : give_up
	// Handshakes judged at the low phase, acted on after the edge
	task automatic wr(input logic [7:0] a, input logic [31:0] v,
		output logic [1:0] r);
		int n;
		logic ta, tw, tb;
		{ta, tw, tb} = 3'b000;
		repeat (lag) @(posedge aclk);
		{s_axi_awvalid, s_axi_awaddr} <= {1'b1, a};
		{s_axi_wvalid, s_axi_wdata} <= {1'b1, v};
		for (n = 0; n < 200 && !tb; n++)
		begin
			@(negedge aclk);
			{ta, tw} = {ta | s_axi_awready, tw | s_axi_wready};
			{tb, r} = {s_axi_bvalid, s_axi_bresp};
			@(posedge aclk);
			if (ta && s_axi_awvalid) {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
			if (tw && s_axi_wvalid) {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~v};
		end
		if (!tb) give_up();
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		logic ta, tr;
		tr = 1'b0;
		{s_axi_arvalid, s_axi_araddr} <= {1'b1, a};
		for (n = 0; n < 200 && !tr; n++)
		begin
			@(negedge aclk);
			{ta, tr, d, r} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
			@(posedge aclk);
			if (ta && s_axi_arvalid) {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
		end
		if (!tr) give_up();
	endtask : rd
endmodule : host_ctl

// File: tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
	bad_count++; $display("Error %s exp %h got %h", n, e, g); end end
module tb_top;
	import trig_seq_pkg::*;
	// ****
	// Bench
	// ****
	logic        aclk, aresetn, local_key, err_push, local_mode, iface_serial;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, save_strobe;
	logic [15:0] err_code, e;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic [4:0]  bus_address;
	setpoint_type    active_setpoint;
	saved_state_type saved_state;
	int          bad_count = 0, num_checks = 0, i;
	// Four cycles a second keeps delays short
	trig_seq #(.TICKS(4)) trig_seq_i (.*);
	host_ctl host_ctl_i (.*);
	initial
	begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	task automatic put(input logic [7:0] a, input logic [31:0] v);
		host_ctl_i.wr(a, v, r);
	endtask : put
	task automatic get(input logic [7:0] a);
		host_ctl_i.rd(a, d, r);
	endtask : get
	task automatic fin(input string s);
		$display("test %s done", s);
	endtask : fin
	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_sim
	initial
	begin
		{aresetn, local_key, err_push, err_code} = 19'h0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		get(VERSION_OFS);
		`CHK("version", {12'h0, VERSION_BCD}, d)
		get(CTRL_OFS);
		`CHK("ctrl", {23'h0, ADDR_RST, 4'h0}, d)
		get(8'h40);
		`CHK("unmapped", 2'b11, r)
		put(CTRL_OFS, 32'hA2);
		`CHK("address", 5'h0A, bus_address)
		`CHK("iface", 1'b1, iface_serial)
		put(ACT_V_OFS, 32'h1234);
		get(STG_V_OFS);
		`CHK("track", 32'h1234, d)
		put(STG_V_OFS, 32'h0100);
		put(STG_I_OFS, {14'h0, KEY_MAX, 16'h0});
		`CHK("active", 16'h1234, active_setpoint.volt)
		put(QSEL_OFS, 32'h2);
		get(STG_V_OFS);
		`CHK("vmax", {16'h0, VOLT_MAX}, d)
		put(QSEL_OFS, 32'h0);
		put(CMD_OFS, 32'h2);
		get(ERR_OFS);
		`CHK("unarmed", {15'h0, 1'b1, ERR_TRIG_IGN}, d)
		fin("setup");
		// Host finishes setup before arming
		put(DELAY_OFS, 32'h3);
		put(CMD_OFS, 32'h1);
		put(CMD_OFS, 32'h2);
		get(STATUS_OFS);
		`CHK("refused", 2'b10, r)
		put(ACT_V_OFS, 32'h0777);
		`CHK("wr refused", 2'b10, r)
		`CHK("early", 16'h1234, active_setpoint.volt)
		for (i = 0; i < 99 && active_setpoint.volt !== 16'h0100; i++)
			@(negedge aclk);
		if (i == 99) host_ctl_i.give_up();
		@(posedge aclk);
		`CHK("copied", {16'h0100, CURR_MAX}, active_setpoint)
		put(ACT_V_OFS, 32'h2222);
		get(STG_V_OFS);
		`CHK("kept", 32'h0100, d)
		put(CTRL_OFS, 32'hA3);
		get(CTRL_OFS);
		`CHK("source", 32'hA3, d)
		host_ctl_i.lag = 2;
		put(CMD_OFS, 32'h1);
		`CHK("immediate", 16'h0100, active_setpoint.volt)
		put(ACT_V_OFS, 32'h2222);
		put(CMD_OFS, 32'h2);
		host_ctl_i.lag = 0;
		`CHK("ignored", 16'h2222, active_setpoint.volt)
		get(ERR_OFS);
		`CHK("no error", 32'h0, d)
		fin("trigger");
		for (i = 1; i <= 21; i++)
		begin
			err_push <= 1'b1;
			err_code <= 16'(i);
			@(posedge aclk);
		end
		err_push <= 1'b0;
		for (i = 1; i <= 20; i++)
		begin
			e = (i < 20) ? 16'(i) : ERR_OVERFLOW;
			get(ERR_OFS);
			`CHK("queue", {15'h0, 1'b1, e}, d)
		end
		get(ERR_OFS);
		`CHK("drained", 32'h0, d)
		fin("queue");
		put(CTRL_OFS, 32'hA2);
		put(CMD_OFS, 32'h1);
		put(CMD_OFS, 32'h2);
		local_key <= 1'b1;
		@(posedge aclk);
		local_key <= 1'b0;
		for (i = 0; i < 9 && local_mode !== 1'b1; i++)
			@(negedge aclk);
		if (i == 9) host_ctl_i.give_up();
		@(posedge aclk);
		`CHK("local", 1'b1, local_mode)
		`CHK("forced", 16'h0100, active_setpoint.volt)
		put(CMD_OFS, 32'h20);
		put(CTRL_OFS, 32'hA3);
		put(DELAY_OFS, 32'h7);
		put(CMD_OFS, 32'h8);
		`CHK("saved", {16'h7, 1'b1}, saved_state[16:0])
		put(CMD_OFS, 32'h4);
		get(CTRL_OFS);
		`CHK("reset src", 32'hA2, d)
		get(DELAY_OFS);
		`CHK("reset delay", 32'h0, d)
		fin("local and save");
		end_sim();
	end
endmodule : tb_top

// File: tb/trig_seq_sva.sv
`timescale 1ns/1ps
module trig_seq_sva
	import trig_seq_pkg::*;
(
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Bus requests and answers
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_bvalid,
	// Panel key and device outputs
	input wire logic        local_key,
	input wire logic        local_mode,
	input wire logic        iface_serial,
	input wire logic [4:0]  bus_address,
	input wire logic        save_strobe
);
	// ****
	// Checks
	// ****
	logic [7:0] ra_q;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Read data carries no address, so keep it
	always_ff @(posedge aclk)
		if (s_axi_arvalid && s_axi_arready) ra_q <= s_axi_araddr;

	a_addr_reset: assert property (disable iff (1'b0)
		!aresetn |=> bus_address == ADDR_RST) else $error("bad reset address");
	// Response is raised on the same edge that applies the write
	a_iface_write: assert property ($changed(iface_serial)
		|-> s_axi_bvalid) else $error("port changed without write");
	a_addr_write: assert property ($changed(bus_address)
		|-> s_axi_bvalid) else $error("address changed without write");
	a_local_key: assert property ($rose(local_mode)
		|-> $past(local_key) || $past(local_key, 2)) else $error("no key");
	a_save_pulse: assert property (save_strobe |=> !save_strobe)
		else $error("save strobe too long");
	a_refuse_zero: assert property (s_axi_rvalid
		&& s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0)
		else $error("refused read carried data");
	a_err_empty: assert property (s_axi_rvalid && ra_q == ERR_OFS
		&& !s_axi_rdata[ERR_VALID_BIT] |-> s_axi_rdata == 32'h0)
		else $error("empty queue read not zero");
	a_version_word: assert property (s_axi_rvalid
		&& ra_q == VERSION_OFS && s_axi_rresp == 2'b00
		|-> s_axi_rdata == {12'h0, VERSION_BCD}) else $error("bad version");
endmodule : trig_seq_sva

bind trig_seq trig_seq_sva trig_seq_sva_i (.*);
